//--- design/usb_port_pkg.sv
package usb_port_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets
  localparam logic [7:0] PORT_SC_OFS  = 8'h00;
  localparam logic [7:0] HOST_STS_OFS = 8'h04;

  // port status and control fields
  localparam int CONN_BIT  = 0;
  localparam int PEN_BIT   = 2;
  localparam int FRES_BIT  = 6;
  localparam int SUSP_BIT  = 7;
  localparam int PRST_BIT  = 8;
  localparam int LN_DM_BIT = 10;
  localparam int LN_DP_BIT = 11;
  localparam int PPWR_BIT  = 12;

  // host status register field
  localparam int STOP_BIT  = 12;

  // values after reset
  localparam logic PEN_RST  = 1'b0;
  localparam logic FRES_RST = 1'b0;
  localparam logic PRST_RST = 1'b0;
  localparam logic PPWR_RST = 1'b0;

  // line state and port state codes, {enable, suspend}
  localparam logic [1:0] LN_K    = 2'h1;
  localparam logic [1:0] PS_DIS  = 2'h0;
  localparam logic [1:0] PS_EN   = 2'h2;
  localparam logic [1:0] PS_SUSP = 2'h3;

  // synchronised pin lanes
  localparam int SYNC_W  = 4;
  localparam int SY_DP   = 0;
  localparam int SY_DM   = 1;
  localparam int SY_CONN = 2;
  localparam int SY_HS   = 3;

  // timing
  localparam int CLK_MHZ        = 50;
  localparam int T_RST_END_US   = 10;
  localparam int RST_END_CYC    = T_RST_END_US * CLK_MHZ;
  localparam int T_RST_LIMIT_MS = 2;
  localparam int RST_LIMIT_CYC  = T_RST_LIMIT_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {
    st_disabled,
    st_enabled,
    st_susp_wait,
    st_suspended
  } port_st_e;

  typedef enum logic [1:0] {
    sq_idle,
    sq_drive,
    sq_finish
  } seq_st_e;

endpackage

//--- design/reset_seq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface reset_seq_if;
  logic start;    // begin bus reset signalling
  logic rel;      // software ended the reset
  logic abort;    // port power off
  logic hs;       // high-speed handshake seen
  logic halted;   // controller stopped
  logic busy;     // reset still in progress
  logic drive;    // reset signalling on the wire
  logic done;     // reset complete, one cycle
  logic done_hs;  // high-speed result at completion
  modport seq (input start, rel, abort, hs, halted,
               output busy, drive, done, done_hs);
  modport ctl (output start, rel, abort, hs, halted,
               input busy, drive, done, done_hs);
endinterface
`default_nettype wire

//--- design/line_sync.sv
`timescale 1ns/1ps
`default_nettype none
module line_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,     // system clock
  input  wire logic         resetn,  // async reset, active low
  input  wire logic [W-1:0] d,       // asynchronous inputs
  output logic      [W-1:0] q        // synchronised outputs
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_r;
      logic s2_r;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else begin
          s1_r <= d[i];
          s2_r <= s1_r;
        end
      end
      assign q[i] = s2_r;
    end
  endgenerate
endmodule
`default_nettype wire

//--- design/bus_reset_seq.sv
`timescale 1ns/1ps
`default_nettype none
module bus_reset_seq
  import usb_port_pkg::*;
#(
  parameter int END_CYC = RST_END_CYC
) (
  input  wire logic clk,     // system clock
  input  wire logic resetn,  // async reset, active low
  reset_seq_if.seq  rif      // link to port control
);
  localparam int CW = $clog2(END_CYC + 1);

  seq_st_e       st_r;
  seq_st_e       st_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          drive_r;
  logic          drive_nxt;
  logic          done_r;
  logic          done_nxt;
  logic          hs_r;
  logic          hs_nxt;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    hs_nxt   = hs_r;
    case (st_r)
      sq_idle: begin
        st_nxt = sq_idle;
      end
      sq_drive: begin
        if (rif.rel) begin
          st_nxt  = sq_finish;
          cnt_nxt = '0;
        end
      end
      sq_finish: begin
        // a stopped controller keeps the reset pending
        if (!rif.halted) begin
          if (cnt_r == CW'(END_CYC - 1)) begin
            st_nxt   = sq_idle;
            done_nxt = 1'b1;
            hs_nxt   = rif.hs;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end
      default: begin
        st_nxt = sq_idle;
      end
    endcase
    if (rif.start) begin
      st_nxt   = sq_drive;
      done_nxt = 1'b0;
    end
    if (rif.abort) begin
      st_nxt   = sq_idle;
      done_nxt = 1'b0;
    end
    drive_nxt = (st_nxt == sq_drive);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r    <= sq_idle;
      cnt_r   <= '0;
      drive_r <= 1'b0;
      done_r  <= 1'b0;
      hs_r    <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      drive_r <= drive_nxt;
      done_r  <= done_nxt;
      hs_r    <= hs_nxt;
    end
  end

  assign rif.busy    = (st_r != sq_idle);
  assign rif.drive   = drive_r;
  assign rif.done    = done_r;
  assign rif.done_hs = hs_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence run_out_s;
    st_r == sq_finish && !rif.halted && cnt_r == CW'(END_CYC - 1)
      && !rif.abort && !rif.start;
  endsequence

  finish_hold_a: assert property (
    (st_r == sq_finish && rif.halted && !rif.abort && !rif.start)
      |=> st_r == sq_finish)
    else $error("reset completed while controller stopped");

  end_time_a: assert property (
    run_out_s |=> rif.done && !rif.busy)
    else $error("reset did not complete on its final count");

endmodule
`default_nettype wire

//--- design/usb_root_port.sv
// Behaviour
// - state from enable and suspend: 0X disabled, 10 enabled, 11 suspended
// - a suspended port blocks all downstream data except reset signalling
// - suspend during a transaction takes effect when that transaction ends
// - a suspended port still watches the line for resume signalling
// - suspend bit reads one only once the port is really suspended
// - writing zero to the suspend bit changes nothing
// - suspend clears on force-resume falling or port reset rising
// - suspend reads zero whenever port power is off
// - port reset rising starts bus reset; clearing it ends the signalling (a write that also turns power on sets the bit but starts no bus reset)
// - port reset keeps reading one until the reset really finished
// - a high-speed port is enabled automatically when reset completes
// - reset completes and settles within 2 ms of software clearing it
// - reset may stay pending while the controller is stopped
// - port reset reads zero whenever port power is off
// - line state shows D+ at bit 11 and D- at bit 10
// - line state is meaningless and disregarded while power is off
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module usb_root_port
  import usb_port_pkg::*;
#(
  parameter int RST_LIMIT = RST_LIMIT_CYC,  // settle bound after reset
  parameter int RST_END   = RST_END_CYC     // reset completion delay
) (
  input  wire logic              clk,                // 50 MHz clock
  input  wire logic              resetn,             // async, active low
  input  wire logic [ADDR_W-1:0] addr,               // register address
  input  wire logic [DATA_W-1:0] wdata,              // write data
  input  wire logic              wr,                 // write strobe
  input  wire logic              rd,                 // read strobe
  output logic      [DATA_W-1:0] rdata,              // read data, next cycle
  input  wire logic              dp_pin,             // D+ line level
  input  wire logic              dm_pin,             // D- line level
  input  wire logic              connect_pin,        // device attached
  input  wire logic              hs_chirp_pin,       // high-speed handshake
  input  wire logic              txn_active,         // transaction running
  input  wire logic              controller_stopped, // controller halted
  output logic                   bus_reset_drive,    // drive bus reset
  output logic                   downstream_block,   // gate downstream data
  output logic      [1:0]        port_state          // {enable, suspend}
);

  reset_seq_if rif();

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;

  assign pins_raw = {hs_chirp_pin, connect_pin, dm_pin, dp_pin};

  line_sync #(.W(SYNC_W)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (pins_raw),
    .q      (pins_s)
  );

  bus_reset_seq #(.END_CYC(RST_END)) u_seq (
    .clk    (clk),
    .resetn (resetn),
    .rif    (rif)
  );

  port_st_e          st_r;
  port_st_e          st_nxt;
  logic              pen_r;
  logic              pen_nxt;
  logic              fres_r;
  logic              fres_nxt;
  logic              prst_r;
  logic              prst_nxt;
  logic              ppwr_r;
  logic              ppwr_nxt;
  logic              blk_r;
  logic              blk_nxt;
  logic [1:0]        ps_r;
  logic [1:0]        ps_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  logic              wr_sc;
  logic              rd_sc;
  logic              start;
  logic              rel;
  logic              fres_fall;
  logic              susp_req;
  logic              resume_k;
  logic              prst_rd;
  logic              susp_rd;
  logic [1:0]        lstate;

  assign wr_sc = wr && (addr == PORT_SC_OFS);
  assign rd_sc = rd && (addr == PORT_SC_OFS);

  // line state is forced quiet without power so nothing acts on it
  assign lstate = ppwr_r ? {pins_s[SY_DP], pins_s[SY_DM]}
                         : 2'h0;

  assign start     = wr_sc && wdata[PRST_BIT] && !prst_r && ppwr_r;
  assign rel       = wr_sc && !wdata[PRST_BIT] && prst_r;
  assign fres_fall = wr_sc && fres_r && !wdata[FRES_BIT];
  // only a one requests suspend; a zero is no request at all
  assign susp_req  = wr_sc && wdata[SUSP_BIT] && pen_r;
  assign resume_k  = (st_r == st_suspended) && (lstate == LN_K);
  assign prst_rd   = ppwr_r && (prst_r || rif.busy);
  assign susp_rd   = ppwr_r && (st_r == st_suspended);

  assign rif.start  = start;
  assign rif.rel    = rel;
  assign rif.abort  = !ppwr_r;
  assign rif.hs     = pins_s[SY_HS];
  assign rif.halted = controller_stopped;

  always_comb begin
    ppwr_nxt = wr_sc ? wdata[PPWR_BIT] : ppwr_r;
    prst_nxt = wr_sc ? wdata[PRST_BIT] : prst_r;
    fres_nxt = wr_sc ? wdata[FRES_BIT] : fres_r;
    if (resume_k) begin
      fres_nxt = 1'b1;                 // resume wins over a clear
    end
    pen_nxt = pen_r;
    if (wr_sc && !wdata[PEN_BIT]) begin
      pen_nxt = 1'b0;
    end
    if (start) begin
      pen_nxt = 1'b0;
    end
    if (rif.done && rif.done_hs) begin
      pen_nxt = 1'b1;
    end

    st_nxt = st_r;
    case (st_r)
      st_disabled: begin
        if (pen_nxt) begin
          st_nxt = st_enabled;
        end
      end
      st_enabled: begin
        if (susp_req) begin
          // a running transaction is allowed to finish first
          st_nxt = txn_active ? st_susp_wait : st_suspended;
        end
      end
      st_susp_wait: begin
        if (!txn_active) begin
          st_nxt = st_suspended;
        end
      end
      st_suspended: begin
        st_nxt = st_suspended;
      end
      default: begin
        st_nxt = st_disabled;
      end
    endcase
    if (fres_fall || start) begin
      st_nxt = st_enabled;
    end
    if (!pen_nxt) begin
      st_nxt = st_disabled;
    end
    if (!ppwr_nxt) begin
      st_nxt   = st_disabled;
      prst_nxt = 1'b0;
      pen_nxt  = 1'b0;
      fres_nxt = 1'b0;
    end

    blk_nxt = (st_nxt == st_suspended);
    ps_nxt  = {pen_nxt, st_nxt == st_suspended};

    rdata_nxt = '0;
    if (rd_sc) begin
      rdata_nxt[CONN_BIT]  = pins_s[SY_CONN];
      rdata_nxt[PEN_BIT]   = pen_r;
      rdata_nxt[FRES_BIT]  = fres_r;
      rdata_nxt[SUSP_BIT]  = susp_rd;
      rdata_nxt[PRST_BIT]  = prst_rd;
      rdata_nxt[LN_DP_BIT] = lstate[1];
      rdata_nxt[LN_DM_BIT] = lstate[0];
      rdata_nxt[PPWR_BIT]  = ppwr_r;
    end else if (rd && (addr == HOST_STS_OFS)) begin
      rdata_nxt[STOP_BIT]  = controller_stopped;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r    <= st_disabled;
      pen_r   <= PEN_RST;
      fres_r  <= FRES_RST;
      prst_r  <= PRST_RST;
      ppwr_r  <= PPWR_RST;
      blk_r   <= 1'b0;
      ps_r    <= PS_DIS;
      rdata_r <= '0;
    end else begin
      st_r    <= st_nxt;
      pen_r   <= pen_nxt;
      fres_r  <= fres_nxt;
      prst_r  <= prst_nxt;
      ppwr_r  <= ppwr_nxt;
      blk_r   <= blk_nxt;
      ps_r    <= ps_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata            = rdata_r;
  assign downstream_block = blk_r;
  assign port_state       = ps_r;
  assign bus_reset_drive  = rif.drive;

  // cycles spent finishing a reset, counted from zero again whenever the controller is stopped
  logic [31:0] lim_cnt_r;
  logic [31:0] lim_cnt_nxt;

  always_comb begin
    lim_cnt_nxt = '0;
    if (rif.busy && !prst_r && !controller_stopped) begin
      lim_cnt_nxt = lim_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lim_cnt_r <= '0;
    end else begin
      lim_cnt_r <= lim_cnt_nxt;
    end
  end

  logic keep_port;
  assign keep_port = wr_sc && wdata[PEN_BIT] && wdata[PPWR_BIT]
                     && !start && !fres_fall && ppwr_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence susp_busy_s;
    st_r == st_enabled && susp_req && txn_active && keep_port;
  endsequence

  sequence susp_zero_s;
    st_r == st_suspended && keep_port && !wdata[SUSP_BIT];
  endsequence

  state_code_a: assert property (
    st_r == st_suspended |-> ps_r == PS_SUSP && pen_r)
    else $error("suspended port not shown as enable plus suspend");

  block_a: assert property (
    $rose(st_r == st_suspended) |-> blk_r && downstream_block)
    else $error("suspended port does not block downstream data");

  hold_txn_a: assert property (
    susp_busy_s |=> st_r == st_susp_wait && !blk_r)
    else $error("suspend cut a running transaction");

  susp_take_a: assert property (
    st_r == st_susp_wait && !txn_active && pen_nxt && ppwr_nxt
      && !fres_fall && !start |=> st_r == st_suspended && blk_r)
    else $error("suspend not taken once the transaction ended");

  resume_a: assert property (
    (resume_k && ppwr_nxt) |=> fres_r)
    else $error("resume signalling on a suspended port was missed");

  late_flag_a: assert property (
    (rd_sc && st_r == st_susp_wait) |=> !rdata_r[SUSP_BIT])
    else $error("suspend reported before the port suspended");

  zero_wr_a: assert property (
    susp_zero_s |=> st_r == st_suspended)
    else $error("writing zero to suspend changed the port");

  clear_a: assert property (
    (start || fres_fall) |=> st_r != st_suspended)
    else $error("suspend not cleared by resume end or reset");

  power_off_a: assert property (
    (rd_sc && !ppwr_r) |=> !rdata_r[SUSP_BIT] && !rdata_r[PRST_BIT])
    else $error("suspend or reset read as one without power");

  unpowered_a: assert property (
    !ppwr_r |-> st_r == st_disabled && !prst_r && !blk_r)
    else $error("unpowered port not held disabled and out of reset");

  start_drive_a: assert property (
    start |=> bus_reset_drive)
    else $error("bus reset signalling did not start");

  pr_hold_a: assert property (
    rel |=> rif.busy ##0 prst_r == 1'b0)
    else $error("reset ended the moment software cleared it");

  hs_enable_a: assert property (
    (rif.done && rif.done_hs && ppwr_r && !(wr_sc && !wdata[PPWR_BIT]))
      |=> pen_r)
    else $error("high-speed port not enabled after reset");

  limit_a: assert property (
    lim_cnt_r < RST_LIMIT)
    else $error("reset took longer than its settle bound");

  lstate_a: assert property (
    (rd_sc && ppwr_r) |=> rdata_r[LN_DP_BIT] == $past(pins_s[SY_DP])
      && rdata_r[LN_DM_BIT] == $past(pins_s[SY_DM]))
    else $error("line state bits do not follow D+ and D-");

endmodule
`default_nettype wire

//--- sim/usb_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_dev_model #(
  parameter int CHIRP_CYC = 3
) (
  input  wire logic clk,             // system clock
  input  wire logic resetn,          // async reset, active low
  input  wire logic bus_reset_drive, // host drives bus reset
  input  wire logic attach,          // device plugged in
  input  wire logic slow_dev,        // low-speed device, idles in K
  input  wire logic hs_cap,          // answers the high-speed handshake
  input  wire logic resume_k,        // device signals resume
  output logic      dp_pin,          // D+ level
  output logic      dm_pin,          // D- level
  output logic      connect_pin,     // attach sense
  output logic      hs_chirp_pin     // handshake answered
);
  int   cnt;
  logic hs_mode;
  // the chirp answer comes only after the reset has been seen for a while
  always @(posedge clk or negedge resetn) begin
    if (!resetn || !attach) begin
      cnt <= 0;
      hs_mode <= 1'b0;
    end else if (bus_reset_drive) begin
      cnt <= cnt + 1;
      if (hs_cap && cnt >= CHIRP_CYC) begin
        hs_mode <= 1'b1;
      end
    end
  end
  // detached or under bus reset the pull-downs give SE0
  always_comb begin
    connect_pin = attach;
    hs_chirp_pin = hs_mode;
    dp_pin = 1'b0;
    dm_pin = 1'b0;
    if (attach && !bus_reset_drive) begin
      dp_pin = !(slow_dev || resume_k);
      dm_pin = slow_dev || resume_k;
    end
  end
endmodule
`default_nettype wire

//--- sim/usb_root_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usb_root_port_tb;
  import usb_port_pkg::*;
  localparam int END_N = 8;
  localparam int LIM_N = 64;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] PW = ONE << PPWR_BIT;
  localparam logic [31:0] EN = ONE << PEN_BIT;
  localparam logic [31:0] PE = PW | EN;
  localparam logic [31:0] SU = ONE << SUSP_BIT;
  localparam logic [31:0] RS = ONE << PRST_BIT;
  localparam logic [31:0] FR = ONE << FRES_BIT;
  localparam logic [31:0] CN = ONE << CONN_BIT;
  localparam logic [31:0] DP = ONE << LN_DP_BIT;
  localparam logic [31:0] DM = ONE << LN_DM_BIT;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              dp_pin, dm_pin, connect_pin, hs_chirp_pin;
  logic              txn_active = 1'b0;
  logic              controller_stopped = 1'b0;
  logic              bus_reset_drive, downstream_block;
  logic [1:0]        port_state;
  logic              attach = 1'b0;
  logic              slow_dev = 1'b0;
  logic              hs_cap = 1'b0;
  logic              resume_k = 1'b0;
  int                fails = 0;
  int                comparisons = 0;
  int                cycles = 0;

  always #10 clk = ~clk;

  usb_root_port #(.RST_LIMIT(LIM_N), .RST_END(END_N)) u_usb_root_port (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .dp_pin(dp_pin), .dm_pin(dm_pin),
    .connect_pin(connect_pin), .hs_chirp_pin(hs_chirp_pin),
    .txn_active(txn_active), .controller_stopped(controller_stopped),
    .bus_reset_drive(bus_reset_drive), .downstream_block(downstream_block),
    .port_state(port_state));

  usb_dev_model #(.CHIRP_CYC(3)) u_usb_dev_model (
    .clk(clk), .resetn(resetn), .bus_reset_drive(bus_reset_drive),
    .attach(attach), .slow_dev(slow_dev), .hs_cap(hs_cap),
    .resume_k(resume_k), .dp_pin(dp_pin), .dm_pin(dm_pin),
    .connect_pin(connect_pin), .hs_chirp_pin(hs_chirp_pin));

  task automatic stop_test;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // polls port_state for at most n cycles, then compares
  task automatic wait_st(input logic [1:0] e, input int n);
    int i;
    i = 0;
    #1;
    while (port_state !== e && i < n) begin
      idle(1);
      i++;
    end
    chk(32'(port_state), 32'(e));
  endtask

  task automatic t_after_reset;
    idle(1);
    chk(32'(port_state), 32'(PS_DIS));
    chk(32'(bus_reset_drive), 32'h0000_0000);
    rd_chk(PORT_SC_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(HOST_STS_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask

  task automatic t_power_off;
    attach <= 1'b1;
    wr_reg(PORT_SC_OFS, RS);
    idle(4);
    rd_chk(PORT_SC_OFS, RS | SU, 32'h0000_0000);
    chk(32'(bus_reset_drive), 32'h0000_0000);
    rd_chk(PORT_SC_OFS, DP | DM, 32'h0000_0000);
  endtask

  task automatic t_line_state;
    slow_dev <= 1'b1;
    wr_reg(PORT_SC_OFS, PW);
    idle(4);
    rd_chk(PORT_SC_OFS, DP | DM | CN | EN, DM | CN);
    slow_dev <= 1'b0;
    controller_stopped <= 1'b1;
    idle(4);
    rd_chk(PORT_SC_OFS, DP | DM | CN | EN, DP | CN);
    rd_chk(HOST_STS_OFS, ONE << STOP_BIT, ONE << STOP_BIT);
    controller_stopped <= 1'b0;
  endtask

  task automatic t_reset_full_speed;
    wr_reg(PORT_SC_OFS, PW | RS);
    idle(1);
    chk(32'(bus_reset_drive), 32'h0000_0001);
    rd_chk(PORT_SC_OFS, RS, RS);
    idle(10);
    wr_reg(PORT_SC_OFS, PW);
    idle(1);
    chk(32'(bus_reset_drive), 32'h0000_0000);
    rd_chk(PORT_SC_OFS, RS, RS);
    idle(END_N + 6);
    rd_chk(PORT_SC_OFS, RS | EN, 32'h0000_0000);
    chk(32'(port_state), 32'(PS_DIS));
  endtask

  task automatic t_reset_high_speed;
    hs_cap <= 1'b1;
    wr_reg(PORT_SC_OFS, PW | RS);
    idle(10);
    controller_stopped <= 1'b1;
    wr_reg(PORT_SC_OFS, PW);
    idle(20);
    rd_chk(PORT_SC_OFS, RS | EN, RS);
    controller_stopped <= 1'b0;
    wait_st(PS_EN, LIM_N);
    rd_chk(PORT_SC_OFS, RS | EN, EN);
  endtask

  task automatic t_suspend_resume;
    txn_active <= 1'b1;
    wr_reg(PORT_SC_OFS, PE | SU);
    idle(5);
    chk(32'(port_state), 32'(PS_EN));
    chk(32'(downstream_block), 32'h0000_0000);
    rd_chk(PORT_SC_OFS, SU, 32'h0000_0000);
    txn_active <= 1'b0;
    wait_st(PS_SUSP, 4);
    chk(32'(downstream_block), 32'h0000_0001);
    rd_chk(PORT_SC_OFS, SU, SU);
    wr_reg(PORT_SC_OFS, PE);
    idle(2);
    chk(32'(port_state), 32'(PS_SUSP));
    resume_k <= 1'b1;
    idle(4);
    resume_k <= 1'b0;
    idle(4);
    rd_chk(PORT_SC_OFS, FR, FR);
    wr_reg(PORT_SC_OFS, PE);
    wait_st(PS_EN, 4);
    chk(32'(downstream_block), 32'h0000_0000);
  endtask

  task automatic t_suspend_then_reset;
    wr_reg(PORT_SC_OFS, PE | SU);
    wait_st(PS_SUSP, 4);
    wr_reg(PORT_SC_OFS, PW | RS);
    idle(1);
    chk(32'(bus_reset_drive), 32'h0000_0001);
    rd_chk(PORT_SC_OFS, SU, 32'h0000_0000);
    chk(32'(port_state), 32'(PS_DIS));
    idle(10);
    wr_reg(PORT_SC_OFS, PW);
    wait_st(PS_EN, LIM_N);
  endtask

  task automatic t_power_drop;
    wr_reg(PORT_SC_OFS, PE | SU);
    wait_st(PS_SUSP, 4);
    wr_reg(PORT_SC_OFS, 32'h0000_0000);
    idle(2);
    chk(32'(port_state), 32'(PS_DIS));
    rd_chk(PORT_SC_OFS, SU | RS | EN, 32'h0000_0000);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_after_reset();
    t_power_off();
    t_line_state();
    t_reset_full_speed();
    t_reset_high_speed();
    t_suspend_resume();
    t_suspend_then_reset();
    t_power_drop();
    stop_test();
  end
endmodule
`default_nettype wire
